// ===== pkg/qps_params.svh
`ifndef QPS_PARAMS_SVH
`define QPS_PARAMS_SVH
// register byte offsets
`define QPS_CTRL_OFF 12'h000
`define QPS_STAT_OFF 12'h004
`define QPS_PARAM_SEL_OFF 12'h008
`define QPS_PARAM_VAL_OFF 12'h00c
`define QPS_IMAG_OFF 12'h010
`define QPS_IOP_OFF 12'h014
`define QPS_HEAT_TIME_OFF 12'h018
// ctrl field positions
`define QPS_CTRL_DET_EN 0
`define QPS_CTRL_CLEAR 1
`define QPS_CTRL_HEAT 2
`define QPS_CTRL_RAMP 3
`define QPS_CTRL_SW_INST 4
// parameter limits in millivolts / milliamps, heating time in seconds, signed 32 bit
`define QPS_VMIN_LO (-32'sd20000)
`define QPS_VMIN_HI 32'sd0
`define QPS_VMIN_DEF 32'sd0
`define QPS_VMAX_LO 32'sd1
`define QPS_VMAX_HI 32'sd20000
`define QPS_VMAX_DEF 32'sd12000
`define QPS_VF_LO (-32'sd10000)
`define QPS_VF_HI 32'sd10000
`define QPS_VF_LO_DEF 32'sd0
`define QPS_VF_HI_DEF 32'sd10000
`define QPS_HT_LO 32'sd5
`define QPS_HT_HI 32'sd120
`define QPS_HT_DEF 32'sd15
`define QPS_IMAX_DEF 32'sd100000
`define QPS_IMIN_DEF 32'sd0
// parameter indices
`define QPS_P_VMIN 3'h0
`define QPS_P_VMAX 3'h1
`define QPS_P_VFLO 3'h2
`define QPS_P_VFHI 3'h3
`define QPS_P_HTIME 3'h4
`define QPS_P_IMIN 3'h5
`define QPS_P_IMAX 3'h6
`define QPS_NPARAM 7
// timing
`define QPS_CLK_HZ 200000000
`define QPS_BEEP_NS 1000
`define QPS_BEEP_CYC (`QPS_BEEP_NS / 5)
`define QPS_MATCH_TOL 32'sd50
`endif

// ===== pkg/qps_pkg.sv
`default_nettype none
package qps_pkg;
   typedef enum logic [1:0] {
      QPS_RUN = 2'b00,
      QPS_HEATING = 2'b01,
      QPS_PAUSED = 2'b11,
      QPS_QUENCH = 2'b10
   } qps_state_t;
   typedef struct packed {
      logic [31:0] imag;
      logic sw_normal;
      logic ext_quench;
   } qps_sense_t;
   typedef struct packed {
      logic [31:0] vcmd;
      logic zero_v;
      logic quench_out;
      logic quench_led;
      logic heater_on;
      logic ext_relay;
      logic beep;
   } qps_drive_t;
endpackage
`default_nettype wire

// ===== core/qps_heat_timer.sv
`include "qps_params.svh"
`default_nettype none
module qps_heat_timer #(
   parameter int unsigned TICK_CYC = `QPS_CLK_HZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic abort,
   input wire logic [6:0] seconds,
   output logic busy,
   output logic done
);
   logic [31:0] tick_reg;
   logic [6:0] sec_reg;
   // seconds counter, one tick per TICK_CYC cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_reg <= 32'h0;
         sec_reg <= 7'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            busy <= 1'b0;
         end else if (start && !busy) begin
            busy <= 1'b1;
            tick_reg <= 32'h0;
            sec_reg <= seconds;
         end else if (busy) begin
            if (tick_reg == TICK_CYC - 1) begin
               tick_reg <= 32'h0;
               if (sec_reg == 7'h1) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
               sec_reg <= sec_reg - 7'h1;
            end else begin
               tick_reg <= tick_reg + 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== core/qps_supervisor.sv
// Contract
// [R1] internal quench latches, lights, zeroes, signals
// [R2] quench ignores all but clear requests
// [R3] clearing quench pauses at present current
// [R4] external input acts as quench
// [R5] external input undisableable; open reads deasserted
// [R6] key clear blocked while external asserted
// [R7] config disables internal detection only
// [R8] detection off: limit error, follow magnet
// [R9] external input zeroes output always
// [R10] unheated switch normal: match or quench
// [R11] heating tracks magnet, then holds last
// [R12] external heater relay follows heater state
// [R13] out-of-range entry beeps, keeps old
// [R14] min voltage -20.000..0.000, default 0
// [R15] max voltage 0.001..20.000, default 12
// [R16] follow range -10..+10, default 0..10
// [R17] heating time 5..120 s, default 15
// [R18] current defaults max 100, min 0
// [R19] two remote paths, separate buffers; here one shared APB port, no buffers
// [R20] ramp during heating refused with beep
// [R21] reset clears quench, loads defaults
//
// Implementation choices: the APB register port and the placing of the registers.
`include "qps_params.svh"
`default_nettype none
module qps_supervisor #(
   parameter int unsigned TICK_CYC = `QPS_CLK_HZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire qps_pkg::qps_sense_t sense,
   input wire logic int_quench_det,
   input wire logic key_clear,
   input wire logic remote_clear,
   input wire logic [31:0] vcmd_req,
   output qps_pkg::qps_drive_t drive,
   output logic [31:0] iop_out
);
   import qps_pkg::*;
   qps_state_t state_reg;
   logic det_en_reg;
   logic heat_reg;
   logic heat_dly_reg;
   logic sw_inst_reg;
   logic [2:0] psel_reg;
   logic signed [31:0] param_reg [`QPS_NPARAM];
   logic signed [31:0] iop_reg;
   logic [15:0] beep_cnt_reg;
   logic beep_req;
   logic wr_acc;
   logic rd_acc;
   logic ctrl_wr;
   logic clear_req;
   logic ext_q;
   logic mismatch;
   logic int_q;
   logic quench_evt;
   logic ramp_req;
   logic heat_busy;
   logic heat_done;
   logic signed [31:0] wval;
   logic signed [31:0] err;
   logic in_range;
   logic addr_ok;

   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign ctrl_wr = wr_acc && paddr == `QPS_CTRL_OFF;
   assign wval = pwpdata_s(pwdata);
   // external input is active high so an open pin pulled low is quiet
   assign ext_q = sense.ext_quench; // R5
   assign err = sense.imag - iop_reg;
   assign mismatch = (err > `QPS_MATCH_TOL) || (err < -`QPS_MATCH_TOL);
   // internal detection and unheated switch mismatch both gated by config
   assign int_q = det_en_reg && (int_quench_det || // R7
      (sense.sw_normal && !heat_reg && mismatch)); // R10
   assign quench_evt = int_q || ext_q; // R1 R4
   // key clear refused while external input holds
   assign clear_req = (key_clear && !ext_q) || // R6
      remote_clear || (ctrl_wr && pwdata[`QPS_CTRL_CLEAR]);
   assign ramp_req = ctrl_wr && pwdata[`QPS_CTRL_RAMP];

   function automatic logic signed [31:0] pwpdata_s(input logic [31:0] d);
      pwpdata_s = $signed(d);
   endfunction

   // range check for the selected parameter
   always_comb begin
      unique case (psel_reg)
         `QPS_P_VMIN: in_range = wval >= `QPS_VMIN_LO && wval <= `QPS_VMIN_HI; // R14
         `QPS_P_VMAX: in_range = wval >= `QPS_VMAX_LO && wval <= `QPS_VMAX_HI; // R15
         `QPS_P_VFLO,
         `QPS_P_VFHI: in_range = wval >= `QPS_VF_LO && wval <= `QPS_VF_HI; // R16
         `QPS_P_HTIME: in_range = wval >= `QPS_HT_LO && wval <= `QPS_HT_HI; // R17
         default: in_range = 1'b1;
      endcase
   end

   // quench latch and operating mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= QPS_PAUSED; // R21
      end else begin
         unique case (state_reg)
            QPS_QUENCH: begin
               // only a clear leaves, and a fresh event beats it
               if (clear_req && !quench_evt) begin // R2
                  state_reg <= QPS_PAUSED; // R3
               end
            end
            QPS_HEATING: begin
               if (quench_evt) state_reg <= QPS_QUENCH; // R1
               else if (heat_done) state_reg <= QPS_PAUSED; // R11
            end
            QPS_RUN,
            QPS_PAUSED: begin
               if (quench_evt) state_reg <= QPS_QUENCH; // R1 R4
               else if (heat_busy) state_reg <= QPS_HEATING;
               else if (ramp_req) state_reg <= QPS_RUN;
            end
         endcase
      end
   end

   // operating current register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iop_reg <= 32'sh0;
      end else if (state_reg == QPS_HEATING) begin
         iop_reg <= sense.imag; // R11
      end else if (state_reg == QPS_QUENCH) begin
         iop_reg <= sense.imag; // R3 held value at clear
      end else if (!det_en_reg && sense.sw_normal && !heat_reg) begin
         iop_reg <= sense.imag; // R10
      end else if (!det_en_reg && mismatch) begin
         // step toward magnet current, following it down on a real quench
         iop_reg <= (err > 0) ? iop_reg + `QPS_MATCH_TOL : iop_reg - `QPS_MATCH_TOL; // R8
      end
   end

   // control bits; ignored while quenched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         det_en_reg <= 1'b1;
         heat_reg <= 1'b0;
         sw_inst_reg <= 1'b0;
      end else if (ctrl_wr && state_reg != QPS_QUENCH) begin // R2
         det_en_reg <= pwdata[`QPS_CTRL_DET_EN]; // R7
         sw_inst_reg <= pwdata[`QPS_CTRL_SW_INST];
         heat_reg <= pwdata[`QPS_CTRL_HEAT] && pwdata[`QPS_CTRL_SW_INST];
      end
   end

   // parameter store, defaults at reset, bad entries kept out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psel_reg <= 3'h0;
         param_reg[`QPS_P_VMIN] <= `QPS_VMIN_DEF; // R14 R21
         param_reg[`QPS_P_VMAX] <= `QPS_VMAX_DEF; // R15
         param_reg[`QPS_P_VFLO] <= `QPS_VF_LO_DEF; // R16
         param_reg[`QPS_P_VFHI] <= `QPS_VF_HI_DEF;
         param_reg[`QPS_P_HTIME] <= `QPS_HT_DEF; // R17
         param_reg[`QPS_P_IMIN] <= `QPS_IMIN_DEF; // R18
         param_reg[`QPS_P_IMAX] <= `QPS_IMAX_DEF;
      end else if (wr_acc && state_reg != QPS_QUENCH) begin
         if (paddr == `QPS_PARAM_SEL_OFF) psel_reg <= pwdata[2:0];
         if (paddr == `QPS_PARAM_VAL_OFF && in_range &&
             psel_reg < 3'(`QPS_NPARAM)) begin
            param_reg[psel_reg] <= wval; // R13
         end
      end
   end

   // one beep for a bad entry, or a ramp or heater request refused
   assign beep_req = (wr_acc && state_reg != QPS_QUENCH && paddr == `QPS_PARAM_VAL_OFF &&
      !in_range) || // R13
      (ramp_req && state_reg == QPS_HEATING) || // R20
      (ctrl_wr && state_reg != QPS_QUENCH && pwdata[`QPS_CTRL_HEAT] &&
       !pwdata[`QPS_CTRL_SW_INST]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) beep_cnt_reg <= 16'h0;
      else if (beep_req) beep_cnt_reg <= 16'(`QPS_BEEP_CYC);
      else if (beep_cnt_reg != 16'h0) beep_cnt_reg <= beep_cnt_reg - 16'h1;
   end

   // heater edge; a level start would rerun the heating period after it expires
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) heat_dly_reg <= 1'b0;
      else heat_dly_reg <= heat_reg;
   end

   qps_heat_timer #(.TICK_CYC(TICK_CYC)) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(heat_reg && !heat_dly_reg && state_reg != QPS_HEATING &&
         state_reg != QPS_QUENCH), // R11
      .abort(!heat_reg || state_reg == QPS_QUENCH),
      .seconds(param_reg[`QPS_P_HTIME][6:0]),
      .busy(heat_busy),
      .done(heat_done)
   );

   // outputs registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive <= '0;
         iop_out <= 32'h0;
      end else begin
         drive.quench_led <= state_reg == QPS_QUENCH || quench_evt; // R1
         drive.quench_out <= state_reg == QPS_QUENCH || quench_evt; // R1
         drive.zero_v <= state_reg == QPS_QUENCH || quench_evt; // R9
         drive.vcmd <= (state_reg == QPS_QUENCH || quench_evt) ? 32'h0 : vcmd_req;
         drive.heater_on <= heat_reg;
         drive.ext_relay <= heat_reg; // R12
         drive.beep <= beep_req || beep_cnt_reg > 16'h1;
         iop_out <= iop_reg;
      end
   end

   // apb slave, zero wait; unmapped answers error
   // R19: both remote paths share this port through an outside arbiter
   assign addr_ok = paddr <= `QPS_HEAT_TIME_OFF && paddr[1:0] == 2'b00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `QPS_CTRL_OFF: prdata <= {27'h0, sw_inst_reg, 1'b0, heat_reg, 1'b0, det_en_reg};
               `QPS_STAT_OFF: prdata <= {28'h0, heat_busy, ext_q, state_reg};
               `QPS_PARAM_SEL_OFF: prdata <= {29'h0, psel_reg};
               `QPS_PARAM_VAL_OFF: prdata <= psel_reg < 3'(`QPS_NPARAM) ?
                  param_reg[psel_reg] : 32'h0;
               `QPS_IMAG_OFF: prdata <= sense.imag;
               `QPS_IOP_OFF: prdata <= iop_reg;
               `QPS_HEAT_TIME_OFF: prdata <= param_reg[`QPS_P_HTIME];
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   // latch holds until cleared, never drops on its own
   quench_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
      state_reg == QPS_QUENCH && !clear_req |=> state_reg == QPS_QUENCH)
      else $error("quench latch dropped without clear");
   ext_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
      ext_q |=> drive.zero_v && drive.vcmd == 32'h0)
      else $error("external quench did not zero output");
   key_block_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
      state_reg == QPS_QUENCH && ext_q |=> state_reg == QPS_QUENCH)
      else $error("quench cleared while external input high");
   clear_pause_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
      state_reg == QPS_QUENCH && clear_req && !quench_evt |=> state_reg == QPS_PAUSED)
      else $error("clear did not pause");
   int_quench_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
      int_quench_det && det_en_reg |=> state_reg == QPS_QUENCH ##1 drive.quench_out)
      else $error("internal quench not latched");
   det_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
      !det_en_reg && !ext_q && state_reg == QPS_PAUSED |=> state_reg != QPS_QUENCH)
      else $error("quench with detection off");
   relay_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
      ##1 drive.ext_relay == $past(heat_reg))
      else $error("relay not following heater");
   heat_track_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
      state_reg == QPS_HEATING |=> iop_reg == $past(sense.imag))
      else $error("heating not tracking magnet");
   bad_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
      wr_acc && state_reg != QPS_QUENCH && paddr == `QPS_PARAM_VAL_OFF && !in_range
      |=> $stable(param_reg[psel_reg]) && drive.beep)
      else $error("bad entry stored or no beep");
endmodule
`default_nettype wire

// ===== sim/qps_far_side.sv
`default_nettype none
module qps_far_side (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [31:0] set_imag,
   input wire logic set_sw,
   input wire logic set_ext,
   input wire logic plugged,
   input wire qps_pkg::qps_drive_t drive,
   output qps_pkg::qps_sense_t sense,
   output logic [15:0] bad_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   import qps_pkg::*;
   logic [1:0] ext_age;
   // magnet and detector levels, one cycle behind the bench's request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense <= '0;
      end else begin
         sense.imag <= set_imag;
         sense.sw_normal <= set_sw;
         sense.ext_quench <= plugged & set_ext; // open pin reads low
      end
   end
   // supply must be at zero volts shortly after the detector fires
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_age <= 2'h0;
         bad_cnt <= 16'h0;
      end else begin
         ext_age <= !sense.ext_quench ? 2'h0 : (ext_age == 2'h3 ? ext_age : ext_age + 2'h1);
         if (ext_age == 2'h3 && (!drive.zero_v || drive.vcmd != 32'h0)) begin
            bad_cnt <= bad_cnt + 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/quench_protection_supervisor_tb.sv
`include "qps_params.svh"
`default_nettype none
module quench_protection_supervisor_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import qps_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, perr;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, iop_out, vcmd_req = '0, set_imag = '0, q, m_iop = '0;
   logic [31:0] rng = 32'd72389, v;
   logic int_q = 0, key_c = 0, rem_c = 0, set_sw = 0, set_ext = 0, plugged = 1;
   logic [15:0] bad_cnt;
   qps_sense_t sense;
   qps_drive_t drive;
   int n_mismatch = 0, tests_run = 0;
   int m_par [7] = '{0, 12000, 0, 10000, 15, 0, 100000};
   localparam int ti [12] = '{0, 0, 0, 1, 1, 1, 2, 3, 2, 4, 4, 4};
   localparam int tv [12] = '{1, -20001, -20000, 0, 20001, 20000, -10001, 10001, -10000,
      4, 121, 5};
   localparam int tok [12] = '{0, 0, 1, 0, 0, 1, 0, 0, 1, 0, 0, 1};
   // free-running 200 MHz clock
   always #2.5 pclk = ~pclk;
   qps_supervisor #(.TICK_CYC(10)) qps_supervisor_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
      .int_quench_det(int_q), .key_clear(key_c), .remote_clear(rem_c),
      .vcmd_req(vcmd_req), .drive(drive), .iop_out(iop_out));
   qps_far_side qps_far_side_i (.pclk(pclk), .presetn(presetn), .set_imag(set_imag),
      .set_sw(set_sw), .set_ext(set_ext), .plugged(plugged), .drive(drive), .sense(sense),
      .bad_cnt(bad_cnt));
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return (rng & 32'h0000_7fff) | 32'h0000_0100;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // request stands until pready is sampled high at a rising edge
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) chk("pready", 32'h1, 32'h0);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic sett(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic par_chk(input int i);
      apb(1'b1, `QPS_PARAM_SEL_OFF, i);
      apb(1'b0, `QPS_PARAM_VAL_OFF, 32'h0);
      chk("param", m_par[i], q);
   endtask
   task automatic st_chk(input logic [1:0] s);
      apb(1'b0, `QPS_STAT_OFF, 32'h0);
      chk("state", s, q[1:0]);
   endtask
   task automatic out_chk(input logic z);
      chk("zero_v", z, drive.zero_v);
      chk("quench_out", z, drive.quench_out);
      chk("quench_led", z, drive.quench_led);
      if (z) chk("vcmd", 32'h0, drive.vcmd);
   endtask
   // pulse one of the clear or detector inputs for a cycle
   task automatic pulse(input int k);
      @(posedge pclk);
      int_q <= (k == 0);
      key_c <= (k == 1);
      rem_c <= (k == 2);
      @(posedge pclk);
      {int_q, key_c, rem_c} <= 3'h0;
      sett(2);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // watchdog, well past the longest expected run
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      sett(1);
      out_chk(1'b0);
      st_chk(2'b11);
      apb(1'b0, `QPS_CTRL_OFF, 32'h0);
      chk("det_en", 32'h1, q[0]);
      for (int i = 0; i < 7; i++) par_chk(i);
      apb(1'b0, 12'h01c, 32'h0);
      chk("slverr", 32'h1, perr);
      apb(1'b0, 12'h002, 32'h0);
      chk("slverr", 32'h1, perr);
      $display("test defaults done");
      // boundary and out-of-range entries
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, `QPS_PARAM_SEL_OFF, ti[i]);
         apb(1'b1, `QPS_PARAM_VAL_OFF, tv[i]);
         sett(2);
         chk("beep", !tok[i], drive.beep);
         if (tok[i]) m_par[ti[i]] = tv[i];
         par_chk(ti[i]);
         sett(210);
      end
      $display("test ranges done");
      apb(1'b1, `QPS_CTRL_OFF, 32'h5);
      sett(2);
      chk("beep", 32'h1, drive.beep);
      chk("heater_on", 32'h0, drive.heater_on);
      sett(210);
      v = xs();
      @(posedge pclk) set_imag <= v;
      apb(1'b1, `QPS_CTRL_OFF, 32'h15);
      sett(5);
      chk("heater_on", 32'h1, drive.heater_on);
      chk("ext_relay", 32'h1, drive.ext_relay);
      chk("iop", v, iop_out);
      v = xs();
      @(posedge pclk) set_imag <= v;
      apb(1'b1, `QPS_CTRL_OFF, 32'h1d);
      sett(2);
      chk("beep", 32'h1, drive.beep);
      chk("iop", v, iop_out);
      apb(1'b1, `QPS_CTRL_OFF, 32'h15);
      st_chk(2'b01);
      sett(160);
      st_chk(2'b11);
      m_iop = v;
      @(posedge pclk) set_imag <= xs();
      sett(3);
      chk("iop", m_iop, iop_out);
      apb(1'b1, `QPS_CTRL_OFF, 32'h11);
      sett(2);
      chk("ext_relay", 32'h0, drive.ext_relay);
      @(posedge pclk) set_imag <= m_iop;
      $display("test heater done");
      @(posedge pclk) vcmd_req <= xs();
      pulse(0);
      out_chk(1'b1);
      st_chk(2'b10);
      apb(1'b1, `QPS_PARAM_SEL_OFF, 32'h1);
      apb(1'b1, `QPS_PARAM_VAL_OFF, 32'h7);
      apb(1'b0, `QPS_PARAM_VAL_OFF, 32'h0);
      chk("param", m_par[4], q);
      pulse(2);
      st_chk(2'b11);
      out_chk(1'b0);
      chk("iop", m_iop, iop_out);
      $display("test internal done");
      @(posedge pclk) set_ext <= 1'b1;
      sett(3);
      out_chk(1'b1);
      pulse(1);
      st_chk(2'b10);
      @(posedge pclk) set_ext <= 1'b0;
      pulse(1);
      st_chk(2'b11);
      apb(1'b1, `QPS_CTRL_OFF, 32'h10);
      pulse(0);
      chk("quench_out", 32'h0, drive.quench_out);
      @(posedge pclk) set_ext <= 1'b1;
      sett(3);
      out_chk(1'b1);
      @(posedge pclk) set_ext <= 1'b0;
      pulse(2);
      st_chk(2'b11);
      @(posedge pclk) plugged <= 1'b0;
      set_ext <= 1'b1;
      sett(4);
      chk("quench_out", 32'h0, drive.quench_out);
      @(posedge pclk) set_ext <= 1'b0;
      plugged <= 1'b1;
      $display("test external done");
      v = xs() + 32'h0000_1000;
      @(posedge pclk) set_imag <= v;
      set_sw <= 1'b1;
      sett(5);
      chk("iop", v, iop_out);
      apb(1'b1, `QPS_CTRL_OFF, 32'h11);
      @(posedge pclk) set_imag <= v + 32'd1000;
      sett(3);
      st_chk(2'b10);
      @(posedge pclk) set_sw <= 1'b0;
      set_imag <= v;
      pulse(2);
      st_chk(2'b11);
      chk("supply", 32'h0, bad_cnt);
      $display("test switch done");
      finish_test();
   end
endmodule
`default_nettype wire
